// ==== design/ct_timer_consts.svh ====
`ifndef CT_TIMER_CONSTS_SVH
`define CT_TIMER_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CT_OFS_LOW_COUNT_REG 5'h00
`define CT_OFS_HIGH_COUNT_REG 5'h04
`define CT_OFS_LOW_PERIOD_REG 5'h08
`define CT_OFS_HIGH_PERIOD_REG 5'h0c
`define CT_OFS_TCR 5'h10
`define CT_OFS_GLOBAL_CONTROL_REG 5'h14
// ----------------------------------------
// timer control fields, per half
// ----------------------------------------
`define CT_TCR_HALF 16
`define CT_TCR_STAT 0
`define CT_TCR_INV 1
`define CT_TCR_CP 3
`define CT_TCR_PWID 4
`define CT_TCR_ENA 6
`define CT_TCR_WMASK 32'h00fa00fa
`define CT_ENA_OFF 2'h0
`define CT_ENA_ONCE 2'h1
`define CT_ENA_CONT 2'h2
// ----------------------------------------
// global control fields
// ----------------------------------------
`define CT_GLOBAL_CONTROL_REG_LRS 0
`define CT_GLOBAL_CONTROL_REG_HRS 1
`define CT_GLOBAL_CONTROL_REG_MODE 2
`define CT_GLOBAL_CONTROL_REG_PSC 8
`define CT_GLOBAL_CONTROL_REG_TDDR 12
`define CT_GLOBAL_CONTROL_REG_WMASK 32'h0000f00f
// ----------------------------------------
// reset values
// ----------------------------------------
`define CT_RST_WORD 32'h00000000
`define CT_RST_NIB 4'h0
`define CT_RST_PW 2'h0
`endif

// ==== design/ct_pkg.sv ====
package ct_pkg;
  // configuration selected by the two mode bits
  typedef enum logic [1:0] {
    CT_M64 = 2'b00,
    CT_UNCH = 2'b01,
    CT_WDOG = 2'b10,
    CT_CHAIN = 2'b11
  } ct_mode_t;
endpackage

// ==== design/ct_timer.sv ====
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ct_timer_consts.svh"

module ct_timer import ct_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // timer outputs
  output logic outputPin,
  output logic lowerInterrupt,
  output logic lowerDmaEvent,
  output logic upperInterrupt,
  output logic upperDmaEvent
);

  // narrower buses cannot reach the global control word
  if (ADDR_W < 5) begin : gBadAddr
    $error("ct_timer: ADDR_W must be at least 5");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] beMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic enaOn(input logic [1:0] e);
    return (e == `CT_ENA_ONCE) || (e == `CT_ENA_CONT);
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic ack_q;
  logic [31:0] rdData_q;
  logic [31:0] low_count_reg_q, high_count_reg_q, low_period_reg_q, high_period_reg_q, tcr_q, global_control_reg_q;
  logic [3:0] psCnt_q;
  logic [1:0] done_q, lvl;
  logic tick_q, psTick_q, evLo_q, evHi_q, pin_q;

  // one wait cycle, request taken on the second edge
  wire busReq = read | write;
  wire wrTake = write & ack_q;
  wire [4:0] adr = address[4:0];
  wire upperZero = (ADDR_W == 5) ? 1'b1 : (address >> 5) == '0;
  wire hitCntLo = upperZero && adr == `CT_OFS_LOW_COUNT_REG;
  wire hitCntHi = upperZero && adr == `CT_OFS_HIGH_COUNT_REG;
  wire hitPrdLo = upperZero && adr == `CT_OFS_LOW_PERIOD_REG;
  wire hitPrdHi = upperZero && adr == `CT_OFS_HIGH_PERIOD_REG;
  wire hitTcr = upperZero && adr == `CT_OFS_TCR;
  wire hitTgcr = upperZero && adr == `CT_OFS_GLOBAL_CONTROL_REG;
  wire wrCntLo = wrTake & hitCntLo;
  wire wrCntHi = wrTake & hitCntHi;
  wire wrTcr = wrTake & hitTcr;
  wire wrTgcr = wrTake & hitTgcr;
  wire [31:0] wrTgcrVal = beMerge(global_control_reg_q, writedata, byteenable);
  wire [31:0] tcrRd = (tcr_q & `CT_TCR_WMASK)
      | ({31'h0, lvl[0]} << `CT_TCR_STAT)
      | ({31'h0, lvl[1]} << (`CT_TCR_HALF + `CT_TCR_STAT));
  wire [31:0] tgcrRd = (global_control_reg_q & `CT_GLOBAL_CONTROL_REG_WMASK)
      | ({28'h0, psCnt_q} << `CT_GLOBAL_CONTROL_REG_PSC);
  wire [31:0] rdMux = hitCntLo ? low_count_reg_q
      : hitCntHi ? high_count_reg_q
      : hitPrdLo ? low_period_reg_q
      : hitPrdHi ? high_period_reg_q
      : hitTcr ? tcrRd
      : hitTgcr ? tgcrRd
      : 32'h00000000;

  assign waitrequest = busReq & ~ack_q;
  assign readdata = rdData_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdData_q <= `CT_RST_WORD;
    end else begin
      ack_q <= busReq & ~ack_q;
      if (read & ~ack_q) begin
        rdData_q <= rdMux;
      end
    end
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  ct_mode_t mode;
  assign mode = ct_mode_t'(global_control_reg_q[`CT_GLOBAL_CONTROL_REG_MODE +: 2]);
  wire m64 = mode == CT_M64;
  wire mCh = mode == CT_CHAIN;
  wire mUn = mode == CT_UNCH;
  wire lrs = global_control_reg_q[`CT_GLOBAL_CONTROL_REG_LRS];
  wire hrs = global_control_reg_q[`CT_GLOBAL_CONTROL_REG_HRS];
  wire [1:0] enaLo = tcr_q[`CT_TCR_ENA +: 2];
  wire [1:0] enaHi = tcr_q[`CT_TCR_HALF + `CT_TCR_ENA +: 2];
  wire [3:0] psPrd = global_control_reg_q[`CT_GLOBAL_CONTROL_REG_TDDR +: 4];

  // joined modes need both releases, unchained only its own
  wire loRun = lrs & enaOn(enaLo) & ~done_q[0]
      & (mUn | ((m64 | mCh) & hrs));
  wire hiRun = mUn & hrs & enaOn(enaHi) & ~done_q[1];

  // ----------------------------------------
  // counting
  // ----------------------------------------
  wire [63:0] cnt64 = {high_count_reg_q, low_count_reg_q};
  wire [63:0] prd64 = {high_period_reg_q, low_period_reg_q};
  wire [63:0] sum64 = cnt64 + 64'h1;
  // a zero period never counts and never matches, except the high period when chained
  wire run64 = m64 & loRun & (prd64 != 64'h0);
  wire match64 = cnt64 == prd64;
  wire loEq = low_count_reg_q == low_period_reg_q;
  wire hiEq = high_count_reg_q == high_period_reg_q;
  wire psEq = psCnt_q == psPrd;
  wire loNz = low_period_reg_q != 32'h0;
  wire hiNz = high_period_reg_q != 32'h0;
  // chained prescaler follows the low enable only
  wire hiStep = mCh ? loRun
      : (hiRun & psTick_q & hiNz);
  wire loStep = mCh ? (loRun & tick_q & loNz)
      : (mUn & loRun & loNz);
  wire evLo = run64 ? match64 : (loStep & loEq);
  wire evHi = mUn & hiStep & hiEq;

  wire [63:0] next64 = match64 ? 64'h0 : sum64;
  wire [31:0] loAdv = loEq ? 32'h0 : low_count_reg_q + 32'h1;
  wire [31:0] hiAdv = hiEq ? 32'h0 : high_count_reg_q + 32'h1;
  wire [3:0] psAdv = psEq ? `CT_RST_NIB : psCnt_q + 4'h1;

  wire [31:0] low_count_reg_d = wrCntLo
      ? beMerge(low_count_reg_q, writedata, byteenable)
      : run64 ? next64[31:0]
      : loStep ? loAdv
      : low_count_reg_q;
  wire [31:0] high_count_reg_d = wrCntHi
      ? beMerge(high_count_reg_q, writedata, byteenable)
      : run64 ? next64[63:32]
      : hiStep ? hiAdv
      : high_count_reg_q;
  // 4-bit prescaler runs on clk, the internal clock, only
  wire [3:0] psCnt_d = wrTgcr ? wrTgcrVal[`CT_GLOBAL_CONTROL_REG_PSC +: 4]
      : hiRun ? psAdv
      : psCnt_q;
  // one-shot stop; a new match beats a same-cycle rewrite
  wire [1:0] doneSet = {evHi & (enaHi == `CT_ENA_ONCE),
      evLo & (enaLo == `CT_ENA_ONCE)};
  wire [1:0] done_d = doneSet | (wrTcr ? 2'b00 : done_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_count_reg_q <= `CT_RST_WORD;
      high_count_reg_q <= `CT_RST_WORD;
      psCnt_q <= `CT_RST_NIB;
      done_q <= 2'b00;
    end else begin
      low_count_reg_q <= low_count_reg_d;
      high_count_reg_q <= high_count_reg_d;
      psCnt_q <= psCnt_d;
      done_q <= done_d;
    end
  end

  // ticks come out one cycle after the prescale match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
      psTick_q <= 1'b0;
      evLo_q <= 1'b0;
      evHi_q <= 1'b0;
    end else begin
      tick_q <= mCh & loRun & hiEq;
      psTick_q <= hiRun & psEq;
      evLo_q <= evLo;
      evHi_q <= evHi;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_period_reg_q <= `CT_RST_WORD;
      high_period_reg_q <= `CT_RST_WORD;
      tcr_q <= `CT_RST_WORD;
      global_control_reg_q <= `CT_RST_WORD;
    end else begin
      if (wrTake & hitPrdLo) begin
        low_period_reg_q <= beMerge(low_period_reg_q, writedata, byteenable);
      end
      if (wrTake & hitPrdHi) begin
        high_period_reg_q <= beMerge(high_period_reg_q, writedata, byteenable);
      end
      if (wrTcr) begin
        tcr_q <= beMerge(tcr_q, writedata, byteenable)
            & `CT_TCR_WMASK;
      end
      if (wrTgcr) begin
        global_control_reg_q <= wrTgcrVal & `CT_GLOBAL_CONTROL_REG_WMASK;
      end
    end
  end

  // ----------------------------------------
  // output shaping, one per half
  // ----------------------------------------
  wire [1:0] evH = {evHi, evLo};
  for (genvar h = 0; h < 2; h++) begin : gHalf
    wire cp = tcr_q[h*`CT_TCR_HALF + `CT_TCR_CP];
    wire inv = tcr_q[h*`CT_TCR_HALF + `CT_TCR_INV];
    wire [1:0] pw = tcr_q[h*`CT_TCR_HALF + `CT_TCR_PWID +: 2];
    // per-half state, so each flop has exactly one writing process
    logic stat_q;
    logic [1:0] pwLeft_q;
    assign lvl[h] = stat_q ^ inv;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        stat_q <= 1'b0;
        pwLeft_q <= `CT_RST_PW;
      end else if (evH[h]) begin
        stat_q <= cp ? ~stat_q : 1'b1;
        pwLeft_q <= pw;
      end else if (!cp && stat_q) begin
        if (pwLeft_q == 2'h0) begin
          stat_q <= 1'b0;
        end else begin
          pwLeft_q <= pwLeft_q - 2'h1;
        end
      end
    end
  end

  // high level shows only in its status bit, low drives the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= lvl[0];
    end
  end

  assign outputPin = pin_q;
  assign lowerInterrupt = evLo_q;
  assign lowerDmaEvent = evLo_q;
  assign upperInterrupt = evHi_q;
  assign upperDmaEvent = evHi_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_mode_64: assert property (
    $rose(rst_n) |-> mode == CT_M64)
    else $error("mode not 64-bit after reset");
  a_count_inc_64: assert property (
    run64 && !match64 && !wrCntLo && !wrCntHi
      |=> {high_count_reg_q, low_count_reg_q} == $past(cnt64) + 64'h1)
    else $error("64-bit counter did not step by one");
  a_match_64_evt: assert property (
    run64 && match64 |=> lowerInterrupt && lowerDmaEvent)
    else $error("64-bit match gave no event");
  a_pulse_four_wide: assert property (
    evLo && !gHalf[0].stat_q && !gHalf[0].cp && gHalf[0].pw == 2'h3
      && !wrTcr ##1 !evLo [*4]
      |-> $past(gHalf[0].stat_q, 3) && $past(gHalf[0].stat_q, 2)
      && $past(gHalf[0].stat_q) && gHalf[0].stat_q
      ##1 !gHalf[0].stat_q)
    else $error("pulse width not four cycles");
  a_wrap_to_zero: assert property (
    run64 && match64 && !wrCntLo && !wrCntHi
      |=> low_count_reg_q == 32'h0 && high_count_reg_q == 32'h0)
    else $error("counter not cleared after match");
  a_tcr_stops_64: assert property (
    m64 && !enaOn(enaLo) && !wrCntLo && !wrCntHi
      |=> $stable(low_count_reg_q) && $stable(high_count_reg_q))
    else $error("64-bit counter moved while disabled");
  a_chain_tick: assert property (
    mCh && loRun && hiEq && !wrCntHi
      |=> tick_q && high_count_reg_q == 32'h0)
    else $error("prescaler did not tick and clear");
  a_chain_lo_hold: assert property (
    mCh && !tick_q && !wrCntLo |=> $stable(low_count_reg_q))
    else $error("chained low moved without tick");
  a_unch_hi_pre: assert property (
    mUn && !psTick_q && !wrCntHi |=> $stable(high_count_reg_q))
    else $error("high half moved without prescale tick");
  a_unch_hi_evt: assert property (
    evHi |=> upperInterrupt && upperDmaEvent)
    else $error("high match gave no event");
  a_clock_toggle: assert property (
    evLo && gHalf[0].cp |=> gHalf[0].stat_q != $past(gHalf[0].stat_q))
    else $error("clock mode did not toggle");
  a_oneshot_stop: assert property (
    evLo && enaLo == `CT_ENA_ONCE && !wrTcr |=> !loRun)
    else $error("one-shot did not stop");
  a_lo_release: assert property (
    mUn && !lrs && !wrCntLo |=> $stable(low_count_reg_q))
    else $error("low half counted while held");
  a_event_single: assert property (
    lowerInterrupt |=> !lowerInterrupt)
    else $error("low event longer than one cycle");

  c_match_64: cover property (run64 && match64);
  c_chain_evt: cover property (mCh && evLo);
  c_unch_hi_evt: cover property (mUn && evHi);
  c_clock_pin: cover property ($rose(outputPin));

endmodule

// ==== verification/ct_evt_sink.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// interrupt and dma event receiver model
// ----------------------------------------
module ct_evt_sink (
  // clock
  input wire logic clk,
  // events from the timer
  input wire logic lowerInterrupt,
  input wire logic lowerDmaEvent,
  input wire logic upperInterrupt,
  input wire logic upperDmaEvent,
  // tallies for the bench
  output int lowCount,
  output int highCount,
  output int faults
);
  logic lowPrev_q = 1'b0;
  logic highPrev_q = 1'b0;
  initial begin
    lowCount = 0;
    highCount = 0;
    faults = 0;
  end
  // level-sampling receiver: a held level would be taken as several events
  always @(posedge clk) begin
    lowCount <= lowCount + int'(lowerInterrupt === 1'b1);
    highCount <= highCount + int'(upperInterrupt === 1'b1);
    faults <= faults + int'(lowerDmaEvent !== lowerInterrupt
      || upperDmaEvent !== upperInterrupt
      || (lowerInterrupt && lowPrev_q) || (upperInterrupt && highPrev_q));
    lowPrev_q <= lowerInterrupt;
    highPrev_q <= upperInterrupt;
  end
endmodule

// ==== verification/test_ct_timer.sv ====
`timescale 1ns/100ps
`include "ct_timer_consts.svh"
module test_ct_timer;
  import ct_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, outputPin;
  logic lowerInterrupt, lowerDmaEvent, upperInterrupt, upperDmaEvent;
  int lowCount, highCount, faults, lowEv, highEv, pinHigh;
  int bad_count = 0;
  int comparisons = 0;
  // ----------------------------------------
  // design and event receiver
  // ----------------------------------------
  ct_timer ct_timer_i (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .outputPin(outputPin), .lowerInterrupt(lowerInterrupt),
    .lowerDmaEvent(lowerDmaEvent), .upperInterrupt(upperInterrupt),
    .upperDmaEvent(upperDmaEvent));
  ct_evt_sink ct_evt_sink_i (.clk(clk), .lowerInterrupt(lowerInterrupt),
    .lowerDmaEvent(lowerDmaEvent), .upperInterrupt(upperInterrupt),
    .upperDmaEvent(upperDmaEvent), .lowCount(lowCount),
    .highCount(highCount), .faults(faults));
  initial forever #5 clk = ~clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    if (n >= 20) bad_count++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdChk(input string what, input logic [4:0] a,
                       input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask
  // halt first so count presets are not disturbed by a running half
  task automatic cfg(input logic [31:0] g, clo, chi, plo, phi, t);
    wr(`CT_OFS_TCR, 32'h0);
    wr(`CT_OFS_GLOBAL_CONTROL_REG, 32'h0);
    wr(`CT_OFS_LOW_COUNT_REG, clo);
    wr(`CT_OFS_HIGH_COUNT_REG, chi);
    wr(`CT_OFS_LOW_PERIOD_REG, plo);
    wr(`CT_OFS_HIGH_PERIOD_REG, phi);
    wr(`CT_OFS_GLOBAL_CONTROL_REG, g);
    wr(`CT_OFS_TCR, t);
  endtask
  // window is a whole number of periods, so its phase does not matter
  task automatic measure(input int settle, input int n);
    int l0, h0;
    repeat (settle) @(posedge clk);
    l0 = lowCount;
    h0 = highCount;
    pinHigh = 0;
    repeat (n) begin
      @(posedge clk);
      pinHigh += int'(outputPin === 1'b1);
    end
    lowEv = lowCount - l0;
    highEv = highCount - h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic checkReset;
    rdChk("global after reset", `CT_OFS_GLOBAL_CONTROL_REG, 32'h0);
    rdChk("control after reset", `CT_OFS_TCR, 32'h0);
    wr(5'h18, 32'hffffffff);
    rdChk("unmapped", 5'h18, 32'h0);
    rdChk("global kept", `CT_OFS_GLOBAL_CONTROL_REG, 32'h0);
  endtask
  task automatic checkWideOnce;
    cfg(32'h3, 32'hffffffff, 32'h0, 32'h1, 32'h1, 32'h40);
    measure(0, 30);
    chk("carry one-shot events", lowEv, 1);
    chk("no upper events", highEv, 0);
    rdChk("low count stopped", `CT_OFS_LOW_COUNT_REG, 32'h0);
    rdChk("high count stopped", `CT_OFS_HIGH_COUNT_REG, 32'h0);
  endtask
  task automatic checkPin;
    logic [31:0] t;
    int exp;
    // pulse configs first; a clock-mode level left over is not pulse state
    for (int c = 0; c < 12; c++) begin
      t = 32'h80 | (c[3] << 3) | (c[1:0] << 4) | (c[2] << 1);
      exp = c[3] ? 10 : (c[2] ? 20 - 2 * (c[1:0] + 1) : 2 * (c[1:0] + 1));
      cfg(32'h3, 32'h0, 32'h0, 32'h9, 32'h0, t);
      measure(16, 20);
      chk("continuous events", lowEv, 2);
      chk("pin high cycles", pinHigh, exp);
    end
    cfg(32'h3, 32'h0, 32'h0, 32'h2, 32'h0, 32'h80);
    measure(8, 30);
    chk("period two events", lowEv, 10);
  endtask
  task automatic checkChain;
    cfg({28'h0, CT_CHAIN, 2'b11}, 32'h0, 32'h0, 32'h1, 32'h2, 32'h80);
    measure(16, 36);
    chk("chained low events", lowEv, 6);
    chk("chained upper events", highEv, 0);
  endtask
  task automatic checkSplit;
    cfg(32'h1003 | (CT_UNCH << 2), 32'h0, 32'h0, 32'h4, 32'h1,
        32'h00800080);
    measure(16, 20);
    chk("split low events", lowEv, 4);
    chk("split upper events", highEv, 5);
    wr(`CT_OFS_GLOBAL_CONTROL_REG, 32'h1001 | (CT_UNCH << 2));
    measure(8, 20);
    chk("upper held", highEv, 0);
    chk("low still running", lowEv, 4);
  endtask
  task automatic checkOff;
    cfg(32'h3, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0);
    measure(8, 30);
    chk("disabled events", lowEv, 0);
    cfg(32'h1, 32'h0, 32'h0, 32'h2, 32'h0, 32'h80);
    measure(8, 30);
    chk("half released", lowEv, 0);
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    checkReset;
    checkWideOnce;
    checkPin;
    checkChain;
    checkSplit;
    checkOff;
    chk("event pulse faults", faults, 0);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule
